// >>> rtl/brte_run_test_engine.v
// The placing of the registers and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "brte_regs.vh"

module brte_run_test_engine (
  input  wire        clock,
  input  wire        rst,
  input  wire        tck,
  input  wire        tms,
  input  wire        tdi,
  output reg         tdoOut,
  output reg         tdoOe,
  input  wire [7:0]  dataIn,
  input  wire        pinOeN,
  input  wire        pinLe,
  output reg  [7:0]  dataOut,
  output reg         dataOe,
  output reg  [7:0]  coreIn,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o
);

  localparam CW = `BRTE_CHAIN_WIDTH;
  localparam BW = `BRTE_BCR_WIDTH;

  // 16-bit maximal length: x^16 + x^14 + x^13 + x^11 + 1
  function [15:0] step16;
    input [15:0] s;
    begin
      step16 = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    end
  endfunction

  // 8-bit maximal length: x^8 + x^6 + x^5 + x^4 + 1
  function [7:0] step8;
    input [7:0] s;
    begin
      step8 = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    end
  endfunction

  // bit 7 of the instruction is a don't care
  function [2:0] instrKind;
    input [7:0] ir;
    begin
      case (ir[6:0])
        `BRTE_OP_EXTEST0,
        `BRTE_OP_EXTEST1:  instrKind = `BRTE_KIND_EXTEST;
        `BRTE_OP_SAMPLE:   instrKind = `BRTE_KIND_SAMPLE;
        `BRTE_OP_RUNTEST:  instrKind = `BRTE_KIND_RUNTEST;
        `BRTE_OP_READN,
        `BRTE_OP_READT:    instrKind = `BRTE_KIND_READ;
        `BRTE_OP_SELFTEST: instrKind = `BRTE_KIND_SELF;
        `BRTE_OP_BCRN,
        `BRTE_OP_BCRT:     instrKind = `BRTE_KIND_BCR;
        default:           instrKind = `BRTE_KIND_BYPASS;
      endcase
    end
  endfunction

  function testMode;
    input [7:0] ir;
    begin
      case (ir[6:0])
        `BRTE_OP_EXTEST0, `BRTE_OP_EXTEST1, `BRTE_OP_HIGHZ, `BRTE_OP_CLAMP,
        `BRTE_OP_RUNTEST, `BRTE_OP_READT, `BRTE_OP_BCRT: testMode = 1'b1;
        default: testMode = 1'b0;
      endcase
    end
  endfunction

  // pin synchronisers; stage one feeds stage two only
  reg [12:0] pinMeta_r;
  reg [12:0] pinSync_r;
  reg        tckLast_r;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      pinMeta_r <= 13'h0000;
      pinSync_r <= 13'h0000;
      tckLast_r <= 1'b0;
    end else begin
      pinMeta_r <= {tck, tms, tdi, pinOeN, pinLe, dataIn};
      pinSync_r <= pinMeta_r;
      tckLast_r <= pinSync_r[12];
    end
  end

  wire       tckSync  = pinSync_r[12];
  wire       tmsSync  = pinSync_r[11];
  wire       tdiSync  = pinSync_r[10];
  wire       oeNSync  = pinSync_r[9];
  wire       leSync   = pinSync_r[8];
  wire [7:0] dataSync = pinSync_r[7:0];
  wire       tckRise  = tckSync & ~tckLast_r;
  wire       tckFall  = ~tckSync & tckLast_r;

  wire [3:0] tapState;

  // the tester moves tms after a fall, the controller steps on the next rise
  brte_tap_ctrl u_brte_tap_ctrl (
    .clock    (clock),
    .rst      (rst),
    .tckRise  (tckRise),
    .tmsSync  (tmsSync),
    .tapState (tapState)
  );

  reg [7:0]    irShift_r;
  reg [7:0]    instr_r;
  reg [CW-1:0] chain_r;
  reg [CW-1:0] shadow_r;
  reg [CW-1:0] shadow_nxt;
  reg [BW-1:0] bcr_r;
  reg          bypass_r;
  reg          runPend_r;
  reg [9:0]    core_r;

  wire [2:0] kind     = instrKind(instr_r);
  wire       inTest   = testMode(instr_r);
  wire [1:0] runOp    = bcr_r[1:0];
  wire       runNow   = (kind == `BRTE_KIND_RUNTEST) && (tapState == `BRTE_TAP_RTI);
  wire       boundary = (kind == `BRTE_KIND_EXTEST) || (kind == `BRTE_KIND_SAMPLE) ||
                        (kind == `BRTE_KIND_READ) || (kind == `BRTE_KIND_SELF);

  // next value of the chain's data cells for one run-test step
  reg [15:0] runStep;

  always @* begin
    runStep = chain_r[15:0];
    case (runOp)
      `BRTE_RUN_TOGGLE: runStep = {dataSync, ~chain_r[7:0]};
      `BRTE_RUN_PATTERN: runStep = step16(chain_r[15:0]);
      `BRTE_RUN_SIG16: runStep = step16(chain_r[15:0]) ^ {dataSync, 8'h00};
      `BRTE_RUN_COMBINED: runStep = {step8(chain_r[15:8]) ^ dataSync,
                                     step8(chain_r[7:0])};
      default: runStep = chain_r[15:0];
    endcase
  end

  // rising tck: capture, shift, run steps
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      irShift_r <= `BRTE_IR_RESET;
      chain_r   <= {CW{1'b0}};
      bcr_r     <= `BRTE_BCR_RESET;
      bypass_r  <= 1'b0;
      runPend_r <= 1'b0;
    end else if (tckRise) begin
      runPend_r <= runNow;
      case (tapState)
        `BRTE_TAP_CAPIR: begin
          irShift_r <= `BRTE_IR_CAPTURE;
        end
        `BRTE_TAP_SHIR: begin
          irShift_r <= {tdiSync, irShift_r[7:1]};
        end
        `BRTE_TAP_CAPDR: begin
          case (kind)
            `BRTE_KIND_EXTEST,
            `BRTE_KIND_SAMPLE: chain_r <= {leSync, oeNSync, dataSync, core_r[7:0]};
            `BRTE_KIND_SELF:   chain_r <= ~shadow_r;
            // control register and boundary read keep their contents
            `BRTE_KIND_READ,
            `BRTE_KIND_BCR:    chain_r <= chain_r;
            default:           bypass_r <= 1'b0;
          endcase
        end
        `BRTE_TAP_SHDR: begin
          if (boundary) begin
            chain_r <= {tdiSync, chain_r[CW-1:1]};
          end else if (kind == `BRTE_KIND_BCR) begin
            bcr_r <= {tdiSync, bcr_r[BW-1:1]};
          end else begin
            bypass_r <= tdiSync;
          end
        end
        `BRTE_TAP_RTI: begin
          // control cells 17-16 are left out of every algorithm
          if (runNow) begin
            chain_r <= {chain_r[CW-1:16], runStep};
          end
        end
        default: begin
          chain_r <= chain_r;
        end
      endcase
    end
  end

  // shadow latches move on the falling tck after an extest or sample update, or a run step (cells 7-0 held in sig16)
  always @* begin
    shadow_nxt = shadow_r;
    if (tapState == `BRTE_TAP_UPDR &&
        (kind == `BRTE_KIND_EXTEST || kind == `BRTE_KIND_SAMPLE)) begin
      shadow_nxt = chain_r;
    end else if (runPend_r) begin
      shadow_nxt[15:8] = chain_r[15:8];
      if (runOp != `BRTE_RUN_SIG16) begin
        shadow_nxt[7:0] = chain_r[7:0];
      end else begin
        shadow_nxt[7:0] = shadow_r[7:0];
      end
    end
  end

  wire serialOut = (tapState == `BRTE_TAP_SHIR) ? irShift_r[0] :
                   boundary ? chain_r[0] :
                   (kind == `BRTE_KIND_BCR) ? bcr_r[0] : bypass_r;
  wire shifting  = (tapState == `BRTE_TAP_SHIR) || (tapState == `BRTE_TAP_SHDR);
  wire highZ     = (instr_r[6:0] == `BRTE_OP_HIGHZ);

  // falling tck: tdo, instruction update, shadows, test-mode pins
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      tdoOut   <= 1'b0;
      tdoOe    <= 1'b0;
      instr_r  <= `BRTE_IR_RESET;
      shadow_r <= {CW{1'b0}};
      dataOut  <= 8'h00;
      dataOe   <= 1'b0;
      coreIn   <= 8'h00;
    end else begin
      if (tckFall) begin
        tdoOut   <= shifting ? serialOut : 1'b0;
        tdoOe    <= shifting;
        shadow_r <= shadow_nxt;
        if (tapState == `BRTE_TAP_TLR) begin
          instr_r <= `BRTE_IR_RESET;
        end else if (tapState == `BRTE_TAP_UPIR) begin
          instr_r <= irShift_r;
        end
        if (inTest) begin
          dataOut <= shadow_nxt[7:0];
          // output-enable cell is active low, as the pin it stands for
          dataOe  <= ~shadow_nxt[`BRTE_CELL_OEN] & ~highZ;
        end
      end
      // normal mode drives from the core directly; test mode waits for tck falls
      if (!inTest) begin
        dataOut <= core_r[7:0];
        dataOe  <= ~core_r[`BRTE_CORE_OEN];
        coreIn  <= dataSync;
      end else begin
        coreIn  <= shadow_r[15:8];
      end
    end
  end

  // wishbone slave: ack one cycle after the request, write on the ack edge
  wire wbReq = wb_cyc_i & wb_stb_i;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      core_r   <= `BRTE_CORE_RESET;
    end else begin
      wb_ack_o <= wbReq & ~wb_ack_o;
      if (wbReq && !wb_ack_o) begin
        case (wb_adr_i)
          `BRTE_ADDR_CORE:   wb_dat_o <= {22'h000000, core_r};
          `BRTE_ADDR_STATUS: wb_dat_o <= {10'h000, runNow, inTest, bcr_r, instr_r,
                                          kind, 1'b0, tapState};
          `BRTE_ADDR_CHAIN:  wb_dat_o <= {14'h0000, chain_r};
          `BRTE_ADDR_SHADOW: wb_dat_o <= {14'h0000, shadow_r};
          default:           wb_dat_o <= 32'h00000000;
        endcase
      end
      if (wbReq && wb_ack_o && wb_we_i && wb_adr_i == `BRTE_ADDR_CORE) begin
        if (wb_sel_i[0]) begin
          core_r[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          core_r[9:8] <= wb_dat_i[9:8];
        end
      end
    end
  end

endmodule // brte_run_test_engine
`default_nettype wire

// >>> rtl/brte_regs.vh
`ifndef BRTE_REGS_VH
`define BRTE_REGS_VH

// tap controller state codes
`define BRTE_TAP_TLR      4'h0
`define BRTE_TAP_RTI      4'h1
`define BRTE_TAP_SELDR    4'h2
`define BRTE_TAP_CAPDR    4'h3
`define BRTE_TAP_SHDR     4'h4
`define BRTE_TAP_EX1DR    4'h5
`define BRTE_TAP_PAUSEDR  4'h6
`define BRTE_TAP_EX2DR    4'h7
`define BRTE_TAP_UPDR     4'h8
`define BRTE_TAP_SELIR    4'h9
`define BRTE_TAP_CAPIR    4'ha
`define BRTE_TAP_SHIR     4'hb
`define BRTE_TAP_EX1IR    4'hc
`define BRTE_TAP_PAUSEIR  4'hd
`define BRTE_TAP_EX2IR    4'he
`define BRTE_TAP_UPIR     4'hf

// instruction register
`define BRTE_IR_WIDTH     8
`define BRTE_IR_CAPTURE   8'h81
`define BRTE_IR_RESET     8'hff
`define BRTE_OP_EXTEST0   7'h00
`define BRTE_OP_SAMPLE    7'h02
`define BRTE_OP_EXTEST1   7'h03
`define BRTE_OP_HIGHZ     7'h06
`define BRTE_OP_CLAMP     7'h07
`define BRTE_OP_RUNTEST   7'h09
`define BRTE_OP_READN     7'h0a
`define BRTE_OP_READT     7'h0b
`define BRTE_OP_SELFTEST  7'h0c
`define BRTE_OP_BCRN      7'h0e
`define BRTE_OP_BCRT      7'h0f

// decoded instruction kinds
`define BRTE_KIND_BYPASS  3'h0
`define BRTE_KIND_EXTEST  3'h1
`define BRTE_KIND_SAMPLE  3'h2
`define BRTE_KIND_RUNTEST 3'h3
`define BRTE_KIND_READ    3'h4
`define BRTE_KIND_SELF    3'h5
`define BRTE_KIND_BCR     3'h6

// boundary control register and run-test opcodes
`define BRTE_BCR_WIDTH    4
`define BRTE_BCR_RESET    4'h0
`define BRTE_RUN_TOGGLE   2'h0
`define BRTE_RUN_PATTERN  2'h1
`define BRTE_RUN_SIG16    2'h2
`define BRTE_RUN_COMBINED 2'h3

// boundary chain layout
`define BRTE_CHAIN_WIDTH  18
`define BRTE_CELL_LE      17
`define BRTE_CELL_OEN     16

// wishbone register offsets (byte addresses)
`define BRTE_ADDR_CORE    8'h00
`define BRTE_ADDR_STATUS  8'h04
`define BRTE_ADDR_CHAIN   8'h08
`define BRTE_ADDR_SHADOW  8'h0c
`define BRTE_CORE_RESET   10'h100
`define BRTE_CORE_OEN     8
`define BRTE_CORE_LE      9

`endif

// >>> rtl/brte_tap_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "brte_regs.vh"

module brte_tap_ctrl (
  input  wire       clock,
  input  wire       rst,
  input  wire       tckRise,
  input  wire       tmsSync,
  output wire [3:0] tapState
);

  localparam TLR     = `BRTE_TAP_TLR;
  localparam RTI     = `BRTE_TAP_RTI;
  localparam SELDR   = `BRTE_TAP_SELDR;
  localparam CAPDR   = `BRTE_TAP_CAPDR;
  localparam SHDR    = `BRTE_TAP_SHDR;
  localparam EX1DR   = `BRTE_TAP_EX1DR;
  localparam PAUSEDR = `BRTE_TAP_PAUSEDR;
  localparam EX2DR   = `BRTE_TAP_EX2DR;
  localparam UPDR    = `BRTE_TAP_UPDR;
  localparam SELIR   = `BRTE_TAP_SELIR;
  localparam CAPIR   = `BRTE_TAP_CAPIR;
  localparam SHIR    = `BRTE_TAP_SHIR;
  localparam EX1IR   = `BRTE_TAP_EX1IR;
  localparam PAUSEIR = `BRTE_TAP_PAUSEIR;
  localparam EX2IR   = `BRTE_TAP_EX2IR;
  localparam UPIR    = `BRTE_TAP_UPIR;

  reg [3:0] state_r;
  reg [3:0] state_nxt;

  always @* begin
    case (state_r)
      TLR:     state_nxt = tmsSync ? TLR : RTI;
      RTI:     state_nxt = tmsSync ? SELDR : RTI;
      SELDR:   state_nxt = tmsSync ? SELIR : CAPDR;
      CAPDR:   state_nxt = tmsSync ? EX1DR : SHDR;
      SHDR:    state_nxt = tmsSync ? EX1DR : SHDR;
      EX1DR:   state_nxt = tmsSync ? UPDR : PAUSEDR;
      PAUSEDR: state_nxt = tmsSync ? EX2DR : PAUSEDR;
      EX2DR:   state_nxt = tmsSync ? UPDR : SHDR;
      UPDR:    state_nxt = tmsSync ? SELDR : RTI;
      SELIR:   state_nxt = tmsSync ? TLR : CAPIR;
      CAPIR:   state_nxt = tmsSync ? EX1IR : SHIR;
      SHIR:    state_nxt = tmsSync ? EX1IR : SHIR;
      EX1IR:   state_nxt = tmsSync ? UPIR : PAUSEIR;
      PAUSEIR: state_nxt = tmsSync ? EX2IR : PAUSEIR;
      EX2IR:   state_nxt = tmsSync ? UPIR : SHIR;
      UPIR:    state_nxt = tmsSync ? SELDR : RTI;
      default: state_nxt = TLR;
    endcase
  end

  // advances only on a rising tck edge, with tms sampled there
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= TLR;
    end else if (tckRise) begin
      state_r <= state_nxt;
    end
  end

  assign tapState = state_r;

endmodule // brte_tap_ctrl
`default_nettype wire

// >>> verification/brte_run_test_engine_chk.sv
`timescale 1ns/1ps
`default_nettype none
module brte_run_test_engine_chk (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        tck,
  input wire logic        tdoOut,
  input wire logic        tdoOe,
  input wire logic [7:0]  dataOut,
  input wire logic        dataOe,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  logic mapped;
  assign mapped = wb_adr_i inside {8'h00, 8'h04, 8'h08, 8'h0c};
  property p_ackOne; wb_ack_o |=> !wb_ack_o; endproperty
  a_ackOne: assert property (p_ackOne) else $error("ack longer than one cycle");
  property p_ackAnswer; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ackAnswer: assert property (p_ackAnswer) else $error("request not answered");
  property p_ackCause; $rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i); endproperty
  a_ackCause: assert property (p_ackCause) else $error("ack without request");
  property p_datHold; $changed(wb_dat_o) |-> wb_ack_o; endproperty
  a_datHold: assert property (p_datHold) else $error("read data moved without ack");
  property p_unmapped; wb_ack_o && !wb_we_i && !mapped |-> wb_dat_o == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // the pin falls a few clocks before the synchroniser lets the output move
  property p_tdoFall; $changed(tdoOut) |-> !$past(tck) && !$past(tck, 2); endproperty
  a_tdoFall: assert property (p_tdoFall) else $error("tdo moved with tck high");
  property p_tdoOeFall; $changed(tdoOe) |-> !$past(tck) && !$past(tck, 2); endproperty
  a_tdoOeFall: assert property (p_tdoOeFall) else $error("tdo enable moved with tck high");
  // normal mode follows the core register, so a recent register write excuses a change
  property p_pinsFall;
    $changed(dataOut) || $changed(dataOe) |->
      !$past(tck) || $past(wb_ack_o) || $past(wb_ack_o, 2) || $past(wb_ack_o, 3);
  endproperty
  a_pinsFall: assert property (p_pinsFall) else $error("data pins moved with tck high");
  c_write: cover property (wb_ack_o && wb_we_i);
  c_tdoOn: cover property ($rose(tdoOe));
  c_pinsTest: cover property ($changed(dataOut) && !$past(tck));
endmodule // brte_run_test_engine_chk

bind brte_run_test_engine brte_run_test_engine_chk u_brte_run_test_engine_chk (
  .clock(clock), .rst(rst), .tck(tck), .tdoOut(tdoOut), .tdoOe(tdoOe),
  .dataOut(dataOut), .dataOe(dataOe), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o)
);
`default_nettype wire

// >>> verification/brte_tap_tester.sv
`timescale 1ns/1ps
`default_nettype none
module brte_tap_tester (
  input  wire logic clock,
  output var logic  tck,
  output var logic  tms,
  output var logic  tdi,
  input  wire logic tdoOut
);
  int halfLow = 4;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // tck stands low between frames; tdo is read just before the rise, long settled
  task automatic pulse(input logic tmsV, input logic tdiV, output logic tdoV);
    tms <= tmsV;
    tdi <= tdiV;
    repeat (halfLow) @(posedge clock);
    tdoV = tdoOut;
    tck <= 1'b1;
    repeat (4) @(posedge clock);
    tck <= 1'b0;
  endtask
  // from idle: select, capture, n shift bits lsb first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [17:0] din,
                      output logic [17:0] dout);
    logic b;
    dout = 18'h0;
    pulse(1'b1, ~tdi, b);
    if (ir) pulse(1'b1, ~tdi, b);
    pulse(1'b0, ~tdi, b);
    pulse(1'b0, ~tdi, b);
    for (int i = 0; i < n; i++) begin
      pulse(i == n - 1, din[i], b);
      dout[i] = b;
    end
    pulse(1'b1, ~tdi, b);
    pulse(1'b0, ~tdi, b);
  endtask
endmodule // brte_tap_tester
`default_nettype wire

// >>> verification/test_brte_run_test_engine.sv
`timescale 1ns/1ps
`default_nettype none
module test_brte_run_test_engine;
  logic        clock, rst, tck, tms, tdi, tdoOut, tdoOe, pinOeN, pinLe, dataOe;
  logic [7:0]  dataIn, dataOut, coreIn, wb_adr_i;
  logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [17:0] scanOut;
  int          mismatches = 0;
  int          tests_run = 0;
  int          cycles = 0;

  brte_run_test_engine u_brte_run_test_engine (
    .clock(clock), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdoOut(tdoOut),
    .tdoOe(tdoOe), .dataIn(dataIn), .pinOeN(pinOeN), .pinLe(pinLe), .dataOut(dataOut),
    .dataOe(dataOe), .coreIn(coreIn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  brte_tap_tester u_brte_tap_tester (
    .clock(clock), .tck(tck), .tms(tms), .tdi(tdi), .tdoOut(tdoOut));

  always #12.5 clock = ~clock;

  task automatic results;
    if (mismatches == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      results();
    end
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wbCycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    check("wishbone ack", 32'h1, {31'h0, wb_ack_o});
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clock);
  endtask

  function automatic logic [15:0] stepCells(input logic [1:0] op, input logic [15:0] s,
                                            input logic [7:0] pins);
    logic [15:0] lf;
    logic [7:0]  hi, lo;
    lf = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    hi = {s[14:8], s[15] ^ s[13] ^ s[12] ^ s[11]};
    lo = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    case (op)
      2'h0: return {pins, ~s[7:0]};
      2'h1: return lf;
      2'h2: return lf ^ {pins, 8'h00};
      default: return {hi ^ pins, lo};
    endcase
  endfunction

  task automatic regsCheck;
    wbCycle(1'b0, 8'h00, 32'h0);
    check("core reset", 32'h100, rd);
    wbCycle(1'b0, 8'h10, 32'h0);
    check("unmapped read", 32'h0, rd);
    wbCycle(1'b1, 8'h04, 32'hffffffff);
    wbCycle(1'b0, 8'h04, 32'h0);
    check("status instruction", 32'hff, {24'h0, rd[15:8]});
    wbCycle(1'b1, 8'h00, 32'h0a5);
    repeat (2) @(posedge clock);
    check("normal data", 32'ha5, {24'h0, dataOut});
    check("normal drive", 32'h1, {31'h0, dataOe});
  endtask

  task automatic controlScan;
    u_brte_tap_tester.scan(1'b1, 8, 18'h0e, scanOut);
    check("ir capture", 32'h81, {24'h0, scanOut[7:0]});
    u_brte_tap_tester.scan(1'b0, 4, 18'hb, scanOut);
    check("control first", 32'h0, {28'h0, scanOut[3:0]});
    u_brte_tap_tester.scan(1'b0, 4, 18'h6, scanOut);
    check("control kept", 32'hb, {28'h0, scanOut[3:0]});
    wbCycle(1'b0, 8'h04, 32'h0);
    check("status control", 32'h6, {28'h0, rd[19:16]});
  endtask

  task automatic runOp(input logic [1:0] op, input logic [17:0] seed, input int n,
                       input logic [7:0] pins);
    logic [15:0] s;
    logic        b;
    s = seed[15:0];
    u_brte_tap_tester.scan(1'b1, 8, 18'h0e, scanOut);
    u_brte_tap_tester.scan(1'b0, 4, {16'h0, op}, scanOut);
    u_brte_tap_tester.scan(1'b1, 8, 18'h02, scanOut);
    u_brte_tap_tester.scan(1'b0, 18, seed, scanOut);
    dataIn <= pins;
    repeat (2) u_brte_tap_tester.pulse(1'b0, 1'b1, b);
    wbCycle(1'b0, 8'h08, 32'h0);
    check("chain idle", {14'h0, seed}, rd);
    u_brte_tap_tester.scan(1'b1, 8, 18'h09, scanOut);
    for (int i = 0; i < n; i++) begin
      u_brte_tap_tester.pulse(1'b0, i[0], b);
      s = stepCells(op, s, pins);
    end
    repeat (4) @(posedge clock);
    wbCycle(1'b0, 8'h08, 32'h0);
    check("chain", {14'h0, seed[17:16], s}, rd);
    check("core inputs", {24'h0, s[15:8]}, {24'h0, coreIn});
    check("outputs", {24'h0, (op == 2'h2) ? seed[7:0] : s[7:0]}, {24'h0, dataOut});
    check("output drive", {31'h0, ~seed[16]}, {31'h0, dataOe});
  endtask

  initial begin
    clock = 1'b0;
    rst = 1'b1;
    dataIn = 8'h00;
    pinOeN = 1'b0;
    pinLe = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    regsCheck();
    u_brte_tap_tester.pulse(1'b0, 1'b0, scanOut[0]);
    controlScan();
    runOp(2'h0, 18'h2b4e1, 3, 8'h3c);
    runOp(2'h1, 18'h2b4e1, 5, 8'h00);
    runOp(2'h2, 18'h1c3a5, 4, 8'h96);
    u_brte_tap_tester.halfLow = 7;
    runOp(2'h3, 18'h2b4e1, 4, 8'h5a);
    u_brte_tap_tester.halfLow = 4;
    runOp(2'h1, 18'h20000, 3, 8'hff);
    results();
  end
endmodule // test_brte_run_test_engine
`default_nettype wire
